// ==== logic/fesc_regs.vh ====
// Register offsets, fields, opcodes and timing counts of the flash command sequencer
`ifndef FESC_REGS_VH
`define FESC_REGS_VH
// Register indices on the plain register port (address width 4)
`define FESC_ADDR_CTRL 4'h0
`define FESC_ADDR_INDEX 4'h1
`define FESC_ADDR_PARAM 4'h2
`define FESC_ADDR_STATUS 4'h3
`define FESC_ADDR_SEC 4'h4
`define FESC_ADDR_PROT 4'h5
`define FESC_ADDR_IRQ_STAT 4'h6
`define FESC_ADDR_IRQ_MASK 4'h7
`define FESC_ADDR_KEY_LO 4'h8
`define FESC_ADDR_KEY_HI 4'h9
`define FESC_ADDR_MODE 4'ha
// Status register bit positions
`define FESC_ST_CCF 7
`define FESC_ST_ACC 5
`define FESC_ST_PV 4
`define FESC_ST_VU 1
`define FESC_ST_VL 0
// Security register fields
`define FESC_SEC_UNSEC 0
`define FESC_SEC_LOCK 1
`define FESC_KEY_ENABLE_FIELD_LSB 6
`define FESC_KEY_ENABLE_FIELD_ON 2'h2
// Command opcodes
`define FESC_OP_BLK 8'h09
`define FESC_OP_SECT 8'h0a
`define FESC_OP_UNSEC 8'h0b
`define FESC_OP_KEY 8'h0c
// Required parameter index per command
`define FESC_IX_BLK 3'h1
`define FESC_IX_UNSEC 3'h0
`define FESC_IX_KEY 3'h4
// Address map: bits 23:16 of a global address select a block
`define FESC_BLK_PFLASH 8'hff
`define FESC_BLK_DFLASH 8'h10
`define FESC_KEY_ADDR 24'hfffe00
// Erase time and verify time in ns, converted to 5 ns cycles
`define FESC_CLK_NS 5
`define FESC_ERASE_NS 2000
`define FESC_VERIFY_NS 400
`define FESC_ERASE_CYC (`FESC_ERASE_NS / `FESC_CLK_NS)
`define FESC_VERIFY_CYC (`FESC_VERIFY_NS / `FESC_CLK_NS)
// Interrupt event bits
`define FESC_EV_DONE 0
`define FESC_EV_ACC 1
`define FESC_EV_PV 2
`define FESC_EV_VERR 3
`endif

// ==== logic/fesc_top.v ====
// Flash erase and security command sequencer with register port and interrupt
`timescale 1ns/1ps
`include "fesc_regs.vh"
module fesc_top (
    input wire SYS_CLK,
    input wire RST,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    input wire MODE_OK,
    input wire VERIFY_ERR,
    input wire VERIFY_UNCORR,
    output reg ERASE_BUSY,
    output reg [1:0] ERASE_SCOPE,
    output reg [23:0] ERASE_ADDR,
    output reg IRQ
);
    // Overview of the sequencer
    // Software fills the parameter words through the index and
    // parameter registers, then writes a one to the complete bit
    // of the status register. That write is the launch.
    // At launch the opcode and parameters are checked in one cycle.
    // Any access error or protection fault ends the command at once,
    // so no erase starts on a bad or protected target, save program sector 15 in a program block erase, which checks only bits 14:0.
    // Key verification needs no erase and finishes in two cycles.
    // Erase commands run an erase phase, then a verify phase.
    // The erase phase is shown on the erase strobe outputs, which
    // the flash array uses to pick its target and extent.
    // The verify result comes from the array on two level inputs,
    // sampled on the last verify cycle only.
    // Timing of the phases is fixed; a real array would hand back
    // a done strobe instead, traded here for a simple counter.
    //
    // Register file notes
    // Writes other than the interrupt status clear are dropped
    // while a command runs. This keeps the parameters stable under
    // the sequencer, at the cost of losing writes that arrive early.
    // The key registers are write-only so that the stored key
    // cannot be read back over the port.
    // The lockout bit is read-only and cleared only by reset.
    // The unsecure bit is read-only and set only by a passed
    // unsecure or a matching key.
    //
    // Error flag notes
    // A pending access or protection flag blocks the next launch.
    // Software must clear both before it launches again.
    // Access error wins over protection violation on one launch.
    // Verify flags are cleared at each launch and reflect only the
    // last erase command.
    //
    // Interrupt notes
    // Each completion pulses one event bit per outcome.
    // Events are sticky in the interrupt status register.
    // The interrupt output lags the status by one cycle.
    //
    // Limitations
    // Only the program block and one data block are known targets.
    // Protection is one bit per program sector; program sector 15 shares bit 15 with data.
    // A reset ends any command at once and leaves the array
    // partly erased; software must erase again after reset.
    // Sequencer states, one-hot
    localparam S_IDLE = 4'h1;
    localparam S_ERASE = 4'h2;
    localparam S_VERIFY = 4'h4;
    localparam S_DONE = 4'h8;

    // Phase counter loads, sized to the counter on purpose
    localparam [15:0] ERASE_LAST = `FESC_ERASE_CYC - 1;
    localparam [15:0] VERIFY_LAST = `FESC_VERIFY_CYC - 1;

    reg [3:0] state;
    reg [15:0] cmd_param_array [0:5];
    reg [2:0] param_index_ptr;
    reg cmd_complete_flag;
    reg access_error_flag;
    reg protection_violation_flag;
    reg verify_error_upper;
    reg verify_error_lower;
    reg [7:0] security_reg;
    reg lockout;
    reg [15:0] prot;
    reg [63:0] stored_key;
    reg [3:0] irq_stat;
    reg [3:0] irq_mask;
    reg [15:0] cnt;
    reg [7:0] op;
    reg [3:0] events;
    integer i;

    // Fields of parameter word 0 and the key words
    wire [7:0] opcode = cmd_param_array[0][15:8];
    wire [7:0] gblk = cmd_param_array[0][7:0];
    wire [15:0] goff = cmd_param_array[1];
    wire [63:0] key_in = {cmd_param_array[1], cmd_param_array[2],
                          cmd_param_array[3], cmd_param_array[4]};
    wire [1:0] key_enable_field = security_reg[`FESC_KEY_ENABLE_FIELD_LSB+1:`FESC_KEY_ENABLE_FIELD_LSB];
    wire [15:0] flash_status_reg = {8'h00, cmd_complete_flag, 1'b0, access_error_flag,
                                    protection_violation_flag, 2'b00,
                                    verify_error_upper, verify_error_lower};

    // Block number decoding, used by the block check; the sector check compares with the program block only
    function blk_valid;
        input [7:0] b;
        begin
            blk_valid = (b == `FESC_BLK_PFLASH) || (b == `FESC_BLK_DFLASH);
        end
    endfunction

    // Protection of one program-flash sector: 16 sectors in the 64 KB block
    function sect_prot;
        input [15:0] p;
        input [15:0] a;
        begin
            sect_prot = p[a[15:12]];
        end
    endfunction

    // Launch check, combinational; errors end the command before any erase
    reg chk_acc;
    reg chk_pv;
    always @* begin
        chk_acc = 1'b0;
        chk_pv = 1'b0;
        if (!MODE_OK)
            chk_acc = 1'b1;
        case (opcode)
            `FESC_OP_BLK: begin
                if (param_index_ptr != `FESC_IX_BLK || !blk_valid(gblk))
                    chk_acc = 1'b1;
                else if (gblk == `FESC_BLK_PFLASH && goff[2:0] != 3'h0)
                    chk_acc = 1'b1;
                else if (gblk == `FESC_BLK_DFLASH && goff[0] != 1'b0)
                    chk_acc = 1'b1;
                if (gblk == `FESC_BLK_PFLASH)
                    chk_pv = |prot[14:0];
                else
                    chk_pv = prot[15];
            end
            `FESC_OP_SECT: begin
                if (param_index_ptr != `FESC_IX_BLK || gblk != `FESC_BLK_PFLASH)
                    chk_acc = 1'b1;
                if (goff[2:0] != 3'h0)
                    chk_acc = 1'b1;
                chk_pv = sect_prot(prot, goff);
            end
            `FESC_OP_UNSEC: begin
                if (param_index_ptr != `FESC_IX_UNSEC)
                    chk_acc = 1'b1;
                chk_pv = |prot;
            end
            `FESC_OP_KEY: begin
                if (param_index_ptr != `FESC_IX_KEY)
                    chk_acc = 1'b1;
                if (key_enable_field != `FESC_KEY_ENABLE_FIELD_ON || lockout)
                    chk_acc = 1'b1;
            end
            default: chk_acc = 1'b1;
        endcase
    end

    // Launch is a write of one to the complete flag while it is set
    wire launch = WR && ADDR == `FESC_ADDR_STATUS && WDATA[`FESC_ST_CCF]
                  && cmd_complete_flag;
    // A running command blocks every register write but the interrupt status clear until complete; host must wait anyway
    wire wr_ok = WR && cmd_complete_flag;

    // Sequencer and register file
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state <= S_IDLE;
            for (i = 0; i < 6; i = i + 1)
                cmd_param_array[i] <= 16'h0000;
            param_index_ptr <= 3'h0;
            cmd_complete_flag <= 1'b1;
            access_error_flag <= 1'b0;
            protection_violation_flag <= 1'b0;
            verify_error_upper <= 1'b0;
            verify_error_lower <= 1'b0;
            security_reg <= 8'h80;
            lockout <= 1'b0;
            prot <= 16'h0000;
            stored_key <= 64'h0000000000000000;
            irq_mask <= 4'h0;
            cnt <= 16'h0000;
            op <= 8'h00;
            events <= 4'h0;
            ERASE_BUSY <= 1'b0;
            ERASE_SCOPE <= 2'h0;
            ERASE_ADDR <= 24'h000000;
        end else begin
            events <= 4'h0;
            if (wr_ok) begin
                case (ADDR)
                    `FESC_ADDR_INDEX: param_index_ptr <= WDATA[2:0];
                    `FESC_ADDR_PARAM: if (param_index_ptr < 3'h6)
                        cmd_param_array[param_index_ptr] <= WDATA;
                    `FESC_ADDR_SEC: security_reg[7:1] <= WDATA[7:1];
                    `FESC_ADDR_PROT: prot <= WDATA;
                    `FESC_ADDR_IRQ_MASK: irq_mask <= WDATA[3:0];
                    `FESC_ADDR_KEY_LO: stored_key[31:0] <= {WDATA, WDATA};
                    `FESC_ADDR_KEY_HI: stored_key[63:32] <= {WDATA, WDATA};
                    default: ;
                endcase
                // Error flags clear by writing one
                if (ADDR == `FESC_ADDR_STATUS) begin
                    if (WDATA[`FESC_ST_ACC])
                        access_error_flag <= 1'b0;
                    if (WDATA[`FESC_ST_PV])
                        protection_violation_flag <= 1'b0;
                end
            end
            case (state)
                S_IDLE: begin
                    // Pending errors block launch, as the flag must be clear first
                    if (launch && !access_error_flag && !protection_violation_flag) begin
                        cmd_complete_flag <= 1'b0;
                        verify_error_upper <= 1'b0;
                        verify_error_lower <= 1'b0;
                        op <= opcode;
                        if (chk_acc || chk_pv) begin
                            access_error_flag <= chk_acc;
                            protection_violation_flag <= chk_pv & ~chk_acc;
                            state <= S_DONE;
                        end else if (opcode == `FESC_OP_KEY) begin
                            // Full match releases, mismatch locks out
                            if (key_in == stored_key)
                                security_reg[`FESC_SEC_UNSEC] <= 1'b1;
                            else begin
                                lockout <= 1'b1;
                                access_error_flag <= 1'b1;
                            end
                            state <= S_DONE;
                        end else begin
                            ERASE_BUSY <= 1'b1;
                            ERASE_ADDR <= {gblk, goff};
                            ERASE_SCOPE <= (opcode == `FESC_OP_BLK) ? 2'h1 :
                                           (opcode == `FESC_OP_SECT) ? 2'h2 : 2'h3;
                            cnt <= ERASE_LAST;
                            state <= S_ERASE;
                        end
                    end
                end
                S_ERASE: begin
                    if (cnt == 16'h0000) begin
                        ERASE_BUSY <= 1'b0;
                        cnt <= VERIFY_LAST;
                        state <= S_VERIFY;
                    end else
                        cnt <= cnt - 16'h0001;
                end
                S_VERIFY: begin
                    // Verify result sampled on the last verify cycle
                    if (cnt == 16'h0000) begin
                        verify_error_upper <= VERIFY_ERR | VERIFY_UNCORR;
                        verify_error_lower <= VERIFY_UNCORR;
                        if (op == `FESC_OP_UNSEC && !VERIFY_ERR && !VERIFY_UNCORR)
                            security_reg[`FESC_SEC_UNSEC] <= 1'b1;
                        state <= S_DONE;
                    end else
                        cnt <= cnt - 16'h0001;
                end
                // Completion: flag set one cycle after the result is known,
                // so software never sees complete with stale error flags
                S_DONE: begin
                    cmd_complete_flag <= 1'b1;
                    events[`FESC_EV_DONE] <= 1'b1;
                    events[`FESC_EV_ACC] <= access_error_flag;
                    events[`FESC_EV_PV] <= protection_violation_flag;
                    events[`FESC_EV_VERR] <= verify_error_upper;
                    ERASE_SCOPE <= 2'h0;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end


    // Sticky interrupt status; a new event wins over a write-one clear
    // The clear is not gated by the complete flag, so software may
    // acknowledge an interrupt at any time
    wire [3:0] irq_clr = (WR && ADDR == `FESC_ADDR_IRQ_STAT) ? WDATA[3:0] : 4'h0;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_irq
            always @(posedge SYS_CLK or posedge RST) begin
                if (RST)
                    irq_stat[g] <= 1'b0;
                else if (events[g])
                    irq_stat[g] <= 1'b1;
                else if (irq_clr[g])
                    irq_stat[g] <= 1'b0;
            end
        end
    endgenerate


    // Interrupt level and read data, both registered
    // Read data is zero outside the cycle after a read, so a
    // stale value can never be mistaken for an answer
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
            RDATA <= 16'h0000;
        end else begin
            IRQ <= |(irq_stat & irq_mask);
            if (RD) begin
                case (ADDR)
                    `FESC_ADDR_INDEX: RDATA <= {13'h0000, param_index_ptr};
                    `FESC_ADDR_PARAM: RDATA <= (param_index_ptr < 3'h6) ?
                        cmd_param_array[param_index_ptr] : 16'h0000;
                    `FESC_ADDR_STATUS: RDATA <= flash_status_reg;
                    `FESC_ADDR_SEC: RDATA <= {8'h00, security_reg[7:2], lockout,
                                              security_reg[0]};
                    `FESC_ADDR_PROT: RDATA <= prot;
                    `FESC_ADDR_IRQ_STAT: RDATA <= {12'h000, irq_stat};
                    `FESC_ADDR_IRQ_MASK: RDATA <= {12'h000, irq_mask};
                    `FESC_ADDR_MODE: RDATA <= {12'h000, state};
                    default: RDATA <= 16'h0000; // Key words are write-only
                endcase
            end else
                RDATA <= 16'h0000;
        end
    end
endmodule // fesc_top

// ==== bench/fesc_props.sv ====
// Port-level checks for the flash erase and security sequencer
`timescale 1ns/1ps
`include "fesc_regs.vh"
module fesc_props (
    input wire SYS_CLK,
    input wire RST,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    input wire MODE_OK,
    input wire ERASE_BUSY,
    input wire [1:0] ERASE_SCOPE,
    input wire [23:0] ERASE_ADDR,
    input wire IRQ
);
    localparam int ERASE_CYC = `FESC_ERASE_CYC;
    logic [15:0] busy_cnt;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Busy run length; a counter, as the run is far too long to unroll
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST)
            busy_cnt <= 16'h0000;
        else
            busy_cnt <= ERASE_BUSY ? busy_cnt + 16'h0001 : 16'h0000;
    end
    property p_busy_start;
        $rose(ERASE_BUSY) |-> $past(WR) && $past(ADDR) == `FESC_ADDR_STATUS && $past(WDATA[7])
            && $past(MODE_OK);
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("erase began with no launch");
    property p_busy_len;
        $fell(ERASE_BUSY) |-> busy_cnt == ERASE_CYC;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("erase phase length wrong");
    property p_busy_max;
        ERASE_BUSY |-> busy_cnt < ERASE_CYC;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("erase phase overran");
    property p_mode;
        WR && ADDR == `FESC_ADDR_STATUS && WDATA[7] && !MODE_OK && !ERASE_BUSY |=> !ERASE_BUSY [*3];
    endproperty
    a_mode: assert property (p_mode) else $error("erase ran in a forbidden mode");
    property p_scope;
        ERASE_BUSY |-> ERASE_SCOPE != 2'h0;
    endproperty
    a_scope: assert property (p_scope) else $error("erase without scope");
    property p_hold;
        ERASE_BUSY && $past(ERASE_BUSY) |-> $stable(ERASE_ADDR) && $stable(ERASE_SCOPE);
    endproperty
    a_hold: assert property (p_hold) else $error("erase target moved");
    property p_sect;
        ERASE_BUSY && ERASE_SCOPE == 2'h2 |-> ERASE_ADDR[2:0] == 3'h0
            && ERASE_ADDR[23:16] == `FESC_BLK_PFLASH;
    endproperty
    a_sect: assert property (p_sect) else $error("bad sector target");
    property p_blk;
        ERASE_BUSY && ERASE_SCOPE == 2'h1 |-> (ERASE_ADDR[23:16] == `FESC_BLK_PFLASH
            && ERASE_ADDR[2:0] == 3'h0) || (ERASE_ADDR[23:16] == `FESC_BLK_DFLASH && !ERASE_ADDR[0]);
    endproperty
    a_blk: assert property (p_blk) else $error("bad block target");
    property p_rdata;
        !$past(RD) |-> RDATA == 16'h0000;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
    c_done: cover property ($fell(ERASE_BUSY));
    c_irq: cover property ($rose(IRQ));
    c_all: cover property (ERASE_SCOPE == 2'h3);
endmodule // fesc_props

// ==== bench/fesc_top_tb.sv ====
// Self-checking bench for the flash erase and security sequencer
`timescale 1ns/1ps
`include "fesc_regs.vh"
module fesc_top_tb;
    localparam [15:0] OK = 16'h0080;
    localparam [15:0] ACC = 16'h00a0;
    localparam [15:0] PV = 16'h0090;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg mode_ok = 1'b1;
    reg verify_err = 1'b0;
    reg verify_uncorr = 1'b0;
    wire [15:0] rdata;
    wire erase_busy;
    wire [1:0] erase_scope;
    wire [23:0] erase_addr;
    wire irq;
    reg [23:0] seen_addr = 24'h000000;
    reg [31:0] lfsr = 32'd72157;
    reg [15:0] rv, h, l, off;
    integer n_fail = 0;
    integer num_checks = 0;
    integer i;
    always #2.5 sys_clk = ~sys_clk;
    fesc_top dut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .MODE_OK(mode_ok), .VERIFY_ERR(verify_err), .VERIFY_UNCORR(verify_uncorr),
        .ERASE_BUSY(erase_busy), .ERASE_SCOPE(erase_scope), .ERASE_ADDR(erase_addr), .IRQ(irq));
    // Last block target shown while erasing
    always @(posedge sys_clk) begin
        if (erase_busy && erase_scope == 2'h1)
            seen_addr <= erase_addr;
    end
    function automatic [31:0] lfsr_next(input [31:0] s);
        lfsr_next = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    // Complete flag plus the two verify flags
    function automatic [15:0] vstat(input ve, input vu);
        vstat = {8'h00, 1'b1, 5'h00, ve | vu, vu};
    endfunction
    function automatic [79:0] pw(input [7:0] op, input [7:0] blk, input [15:0] o);
        pw = {48'h0, o, op, blk};
    endfunction
    task automatic final_report;
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input [31:0] exp, input [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic reg_wr(input [3:0] a, input [15:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input [3:0] a, output [15:0] d);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Polls status; a command that never completes ends the run
    task automatic run_cmd(input [79:0] ws, input [2:0] nw, input [2:0] ix, input [15:0] exp,
        input string nm);
        reg [15:0] st;
        integer k;
        for (k = 0; k < nw; k++) begin
            reg_wr(`FESC_ADDR_INDEX, {13'h0, k[2:0]});
            reg_wr(`FESC_ADDR_PARAM, ws[16*k +: 16]);
        end
        reg_wr(`FESC_ADDR_INDEX, {13'h0, ix});
        reg_wr(`FESC_ADDR_STATUS, 16'h0080);
        st = 16'h0000;
        for (k = 0; k < 500 && st[7] !== 1'b1; k++)
            reg_rd(`FESC_ADDR_STATUS, st);
        check(nm, exp, st);
        if (st[7] !== 1'b1)
            final_report;
        reg_wr(`FESC_ADDR_STATUS, 16'h0030);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        reg_rd(`FESC_ADDR_STATUS, rv);
        check("status", OK, rv);
        reg_rd(`FESC_ADDR_SEC, rv);
        check("sec", 16'h0080, rv);
        reg_wr(4'hf, 16'hffff);
        reg_rd(4'hf, rv);
        check("unmapped", 0, rv);
        // Random aligned block erases with random verify outcomes
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            off = lfsr[15:0] & 16'hfff8;
            verify_err <= lfsr[17];
            verify_uncorr <= lfsr[18] & lfsr[19];
            run_cmd(pw(`FESC_OP_BLK, 8'hff, off), 2, 1, vstat(lfsr[17], lfsr[18] & lfsr[19]),
                "blk_verify");
            check("blk_addr", {8'hff, off}, seen_addr);
        end
        verify_err <= 1'b0;
        verify_uncorr <= 1'b0;
        run_cmd(pw(`FESC_OP_BLK, 8'h10, 16'h0002), 2, 1, OK, "blk_dflash");
        run_cmd(pw(`FESC_OP_BLK, 8'hff, 16'h0000), 2, 0, ACC, "blk_index");
        run_cmd(pw(`FESC_OP_BLK, 8'hff, 16'h0004), 2, 1, ACC, "blk_phrase");
        run_cmd(pw(`FESC_OP_BLK, 8'h10, 16'h0001), 2, 1, ACC, "blk_word");
        run_cmd(pw(`FESC_OP_BLK, 8'h20, 16'h0000), 2, 1, ACC, "blk_addr_bad");
        run_cmd(pw(`FESC_OP_SECT, 8'hff, 16'h1238), 2, 1, OK, "sect");
        run_cmd(pw(`FESC_OP_SECT, 8'hff, 16'h0003), 2, 1, ACC, "sect_align");
        run_cmd(pw(`FESC_OP_SECT, 8'hff, 16'h0000), 2, 2, ACC, "sect_index");
        run_cmd(pw(`FESC_OP_UNSEC, 8'h00, 16'h0000), 1, 1, ACC, "unsec_index");
        run_cmd(pw(`FESC_OP_KEY, 8'h00, 16'h0000), 5, 3, ACC, "key_index");
        mode_ok <= 1'b0;
        run_cmd(pw(`FESC_OP_SECT, 8'hff, 16'h0000), 2, 1, ACC, "mode");
        mode_ok <= 1'b1;
        reg_wr(`FESC_ADDR_PROT, 16'hffff);
        run_cmd(pw(`FESC_OP_SECT, 8'hff, 16'h0000), 2, 1, PV, "sect_prot");
        run_cmd(pw(`FESC_OP_BLK, 8'hff, 16'h0000), 2, 1, PV, "blk_prot");
        run_cmd(pw(`FESC_OP_UNSEC, 8'h00, 16'h0000), 1, 0, PV, "unsec_prot");
        reg_wr(`FESC_ADDR_PROT, 16'h0000);
        // Interrupt: done unmasked, then masked error event
        reg_wr(`FESC_ADDR_IRQ_MASK, 16'h0001);
        verify_err <= 1'b1;
        run_cmd(pw(`FESC_OP_UNSEC, 8'h00, 16'h0000), 1, 0, 16'h0082, "unsec_fail");
        verify_err <= 1'b0;
        reg_rd(`FESC_ADDR_SEC, rv);
        check("sec_kept", 16'h0080, rv);
        check("irq_on", 1, irq);
        reg_wr(`FESC_ADDR_IRQ_STAT, 16'h000f);
        reg_wr(`FESC_ADDR_IRQ_MASK, 16'h0000);
        run_cmd(pw(`FESC_OP_KEY, 8'h00, 16'h0000), 5, 2, ACC, "key_ix2");
        reg_rd(`FESC_ADDR_IRQ_STAT, rv);
        check("irq_stat", 16'h0003, rv);
        check("irq_masked", 0, irq);
        reg_wr(`FESC_ADDR_IRQ_STAT, 16'h000f);
        // Backdoor: disabled, mismatch, lockout, then match after reset
        lfsr = lfsr_next(lfsr);
        h = lfsr[15:0];
        l = lfsr[31:16];
        reg_wr(`FESC_ADDR_KEY_HI, h);
        reg_wr(`FESC_ADDR_KEY_LO, l);
        reg_wr(`FESC_ADDR_SEC, 16'h0000);
        run_cmd({l, l, h, h, `FESC_OP_KEY, 8'h00}, 5, 4, ACC, "key_off");
        reg_wr(`FESC_ADDR_SEC, 16'h0080);
        run_cmd({l, l, h, ~h, `FESC_OP_KEY, 8'h00}, 5, 4, ACC, "key_bad");
        run_cmd({l, l, h, h, `FESC_OP_KEY, 8'h00}, 5, 4, ACC, "key_locked");
        reg_rd(`FESC_ADDR_SEC, rv);
        check("sec_lock", 16'h0082, rv);
        do_reset;
        reg_wr(`FESC_ADDR_KEY_HI, h);
        reg_wr(`FESC_ADDR_KEY_LO, l);
        run_cmd({l, l, h, h, `FESC_OP_KEY, 8'h00}, 5, 4, OK, "key_ok");
        reg_rd(`FESC_ADDR_SEC, rv);
        check("sec_open", 16'h0081, rv);
        do_reset;
        run_cmd(pw(`FESC_OP_UNSEC, 8'h00, 16'h0000), 1, 0, OK, "unsec_ok");
        reg_rd(`FESC_ADDR_SEC, rv);
        check("sec_unsec", 16'h0081, rv);
        final_report;
    end
endmodule // fesc_top_tb
bind fesc_top fesc_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MODE_OK(MODE_OK), .ERASE_BUSY(ERASE_BUSY),
    .ERASE_SCOPE(ERASE_SCOPE), .ERASE_ADDR(ERASE_ADDR), .IRQ(IRQ));
